// ==== rtl/csoc_pkg.sv ====
// constants, types and field layout for the clock source and oscillator control block
package csoc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_OSC_TUNING = 8'h00;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'h04;

  // tuning register fields
  localparam int TUN_LFSRC_BIT = 7;
  localparam int TUN_MULT_BIT = 6;
  localparam int TUN_TRIM_LSB = 0;
  localparam int TUN_TRIM_W = 5;
  localparam logic [4:0] TRIM_RESET = 5'h00;

  // control register fields
  localparam int CTL_IDLE_BIT = 7;
  localparam int CTL_FREQ_LSB = 4;
  localparam int CTL_PRIRDY_BIT = 3;
  localparam int CTL_INTSTB_BIT = 2;
  localparam int CTL_SCS_LSB = 0;
  localparam logic [2:0] FREQ_RESET = 3'h4;
  localparam logic [1:0] SCS_RESET = 2'h0;

  // frequency select codes and postscaler masks (fast ticks per output tick - 1)
  localparam logic [2:0] FREQ_8M = 3'h7;
  localparam logic [2:0] FREQ_4M = 3'h6;
  localparam logic [2:0] FREQ_31K = 3'h0;
  localparam logic [7:0] DIV_MASK_LOW = 8'hFF;

  // primary configuration codes that use the internal block
  localparam logic [3:0] CFG_INT_A = 4'h9;
  localparam logic [3:0] CFG_INT_B = 4'h8;

  // switch pause lengths in source cycles
  localparam logic [2:0] OLD_SRC_CYCLES = 3'h2;
  localparam logic [2:0] NEW_SRC_CYCLES = 3'h4;

  typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} csoc_src_e;

  typedef struct packed {
    logic primaryReady;
    logic internalStable;
    logic secondaryRunning;
  } csoc_flags_s;

  typedef struct packed {
    logic primaryTick;
    logic secondaryTick;
    logic fastTick;
    logic slowTick;
    logic startupExpired;
    logic fastStable;
  } csoc_osc_s;

endpackage

// ==== rtl/csoc_sync.sv ====
// two-flop synchroniser with rising edge detect for oscillator and status pins
module csoc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] levelOut,
  output logic [W-1:0] riseOut
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign levelOut = sync_q;
  assign riseOut = sync_q & ~prev_q;

endmodule

// ==== rtl/csoc_ctrl.sv ====
// clock source selection, internal block postscaler, multiplier gating and APB registers
module csoc_ctrl (
  input wire logic clk_sys,
  input wire logic arst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration and neighbours, same clock domain
  input wire logic [3:0] primaryOscConfig,
  input wire logic secondaryOscEnable,
  input wire logic sleepExec,
  // oscillator edges and status pins, asynchronous
  input wire csoc_pkg::csoc_osc_s oscPins,
  // device side
  output logic deviceClkEn,
  output csoc_pkg::csoc_src_e activeSource,
  output logic switchBusy,
  output logic multActive,
  output logic fastOscEnable,
  output logic slowOscEnable,
  output logic watchdogClkEn,
  output logic signed [4:0] fastOscTrim,
  output csoc_pkg::csoc_flags_s srcFlags,
  output logic idleEnter,
  output logic sleepEnter
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  csoc_pkg::csoc_osc_s oscLevel;
  csoc_pkg::csoc_osc_s oscRise;

  csoc_sync #(
    .W($bits(csoc_pkg::csoc_osc_s))
  ) u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .asyncIn(oscPins),
    .levelOut(oscLevel),
    .riseOut(oscRise)
  );

  wire primTick = oscRise.primaryTick;
  wire secTick = oscRise.secondaryTick;
  wire fastTick = oscRise.fastTick;
  wire slowTick = oscRise.slowTick;
  wire startupDone = oscLevel.startupExpired;
  wire fastStable = oscLevel.fastStable;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic lowFreqSourceSelect_q;
  logic multEnable_q;
  logic [4:0] tuningField_q;
  logic idleOnSleep_q;
  logic [2:0] internalFreqSelect_q;
  logic [1:0] clockSourceSelect_q;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire selTuning = (paddr == csoc_pkg::ADDR_OSC_TUNING);
  wire selControl = (paddr == csoc_pkg::ADDR_OSC_CONTROL);
  wire addrHit = selTuning | selControl;
  wire setupPhase = psel & ~penable;
  wire accessDone = psel & penable & pready;
  wire wrTuning = accessDone & pwrite & selTuning;
  wire wrControl = accessDone & pwrite & selControl;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addrHit;

  // multiplier only where the primary config uses the internal block
  wire multAvail = (primaryOscConfig == csoc_pkg::CFG_INT_A) |
                   (primaryOscConfig == csoc_pkg::CFG_INT_B);
  wire freqAllowsMult = (internalFreqSelect_q == csoc_pkg::FREQ_8M) |
                        (internalFreqSelect_q == csoc_pkg::FREQ_4M);

  wire [1:0] scsWrite = pwdata[csoc_pkg::CTL_SCS_LSB +: 2];
  // a secondary request without its oscillator enabled leaves the select untouched
  wire scsRefused = (scsWrite == 2'h1) & ~secondaryOscEnable;

  // ----------------------------------------------------------------
  // register next values
  // ----------------------------------------------------------------
  wire multEnable_d = !multAvail ? 1'b0 :
                      wrTuning ? pwdata[csoc_pkg::TUN_MULT_BIT] : multEnable_q;
  wire [1:0] clockSourceSelect_d = (wrControl & ~scsRefused) ? scsWrite :
                                   clockSourceSelect_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lowFreqSourceSelect_q <= 1'b0;
      tuningField_q <= csoc_pkg::TRIM_RESET;
    end else if (wrTuning) begin
      lowFreqSourceSelect_q <= pwdata[csoc_pkg::TUN_LFSRC_BIT];
      tuningField_q <= pwdata[csoc_pkg::TUN_TRIM_LSB +: csoc_pkg::TUN_TRIM_W];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      multEnable_q <= 1'b0;
    end else begin
      multEnable_q <= multEnable_d;
    end
  end

  // status bits of the control word are never stored, so writes cannot reach them
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idleOnSleep_q <= 1'b0;
      internalFreqSelect_q <= csoc_pkg::FREQ_RESET;
      clockSourceSelect_q <= csoc_pkg::SCS_RESET;
    end else begin
      clockSourceSelect_q <= clockSourceSelect_d;
      if (wrControl) begin
        idleOnSleep_q <= pwdata[csoc_pkg::CTL_IDLE_BIT];
        internalFreqSelect_q <= pwdata[csoc_pkg::CTL_FREQ_LSB +: 3];
      end
    end
  end

  // ----------------------------------------------------------------
  // internal block postscaler
  // ----------------------------------------------------------------
  logic [7:0] postCount_q;
  logic [7:0] divMask;

  always_comb begin
    unique case (internalFreqSelect_q)
      3'h7: divMask = 8'h00;
      3'h6: divMask = 8'h01;
      3'h5: divMask = 8'h03;
      3'h4: divMask = 8'h07;
      3'h3: divMask = 8'h0F;
      3'h2: divMask = 8'h1F;
      3'h1: divMask = 8'h3F;
      3'h0: divMask = csoc_pkg::DIV_MASK_LOW;
    endcase
  end

  // the counter runs free so a new select takes effect without a pause
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      postCount_q <= '0;
    end else if (fastTick) begin
      postCount_q <= postCount_q + 8'h01;
    end
  end

  wire lowSelected = (internalFreqSelect_q == csoc_pkg::FREQ_31K);
  wire postTick = fastTick & ((postCount_q & divMask) == divMask);
  wire useSlowDirect = lowSelected & ~lowFreqSourceSelect_q;
  wire internalTick = useSlowDirect ? slowTick : postTick;

  assign fastOscEnable = ~useSlowDirect;
  assign slowOscEnable = 1'b1;
  assign watchdogClkEn = slowTick;
  // trim feeds the fast oscillator only; the slow tick path never sees it
  assign fastOscTrim = $signed(tuningField_q);
  // the external multiplier quadruples the fast output while this is high
  assign multActive = multEnable_q & multAvail & freqAllowsMult;

  // ----------------------------------------------------------------
  // glitch-free source switch
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SW_RUN, SW_DRAIN_OLD, SW_WAIT_NEW} csoc_sw_e;

  csoc_sw_e swState_q;
  csoc_pkg::csoc_src_e activeSrc_q;
  csoc_pkg::csoc_src_e targetSrc_q;
  logic [2:0] swCount_q;
  csoc_pkg::csoc_src_e reqSrc;

  assign reqSrc = clockSourceSelect_q[1] ? csoc_pkg::SRC_INTERNAL :
                  clockSourceSelect_q[0] ? csoc_pkg::SRC_SECONDARY :
                  csoc_pkg::SRC_PRIMARY;

  function automatic logic srcTick(input csoc_pkg::csoc_src_e s, input logic p,
                                   input logic q, input logic r);
    logic t;
    t = 1'b0;
    unique case (s)
      csoc_pkg::SRC_PRIMARY: t = p;
      csoc_pkg::SRC_SECONDARY: t = q;
      csoc_pkg::SRC_INTERNAL: t = r;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  wire oldTick = srcTick(activeSrc_q, primTick, secTick, internalTick);
  wire newTick = srcTick(targetSrc_q, primTick, secTick, internalTick);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      swState_q <= SW_RUN;
      activeSrc_q <= csoc_pkg::SRC_PRIMARY;
      targetSrc_q <= csoc_pkg::SRC_PRIMARY;
      swCount_q <= '0;
    end else begin
      unique case (swState_q)
        SW_RUN: begin
          if (reqSrc != activeSrc_q) begin
            targetSrc_q <= reqSrc;
            swCount_q <= '0;
            swState_q <= SW_DRAIN_OLD;
          end
        end
        SW_DRAIN_OLD: begin
          if (oldTick) begin
            if (swCount_q == csoc_pkg::OLD_SRC_CYCLES - 3'h1) begin
              swCount_q <= '0;
              swState_q <= SW_WAIT_NEW;
            end else begin
              swCount_q <= swCount_q + 3'h1;
            end
          end
        end
        SW_WAIT_NEW: begin
          if (newTick) begin
            if (swCount_q == csoc_pkg::NEW_SRC_CYCLES - 3'h1) begin
              activeSrc_q <= targetSrc_q;
              swState_q <= SW_RUN;
            end else begin
              swCount_q <= swCount_q + 3'h1;
            end
          end
        end
      endcase
    end
  end

  // the device clock is held off for the whole pause, so no runt edge reaches it
  assign switchBusy = (swState_q != SW_RUN);
  assign activeSource = activeSrc_q;
  assign deviceClkEn = ~switchBusy & oldTick;

  // ----------------------------------------------------------------
  // source flags and sleep decode
  // ----------------------------------------------------------------
  wire runPrimary = ~switchBusy & (activeSrc_q == csoc_pkg::SRC_PRIMARY);
  wire runSecondary = ~switchBusy & (activeSrc_q == csoc_pkg::SRC_SECONDARY);
  wire runInternal = ~switchBusy & (activeSrc_q == csoc_pkg::SRC_INTERNAL);

  // flags are derived from one active source, so two can never be high together
  assign srcFlags.primaryReady = runPrimary & startupDone;
  assign srcFlags.internalStable = runInternal & fastStable & ~useSlowDirect;
  assign srcFlags.secondaryRunning = runSecondary;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idleEnter <= 1'b0;
      sleepEnter <= 1'b0;
    end else begin
      idleEnter <= sleepExec & idleOnSleep_q;
      sleepEnter <= sleepExec & ~idleOnSleep_q;
    end
  end

  // ----------------------------------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------------------------------
  wire [7:0] tuningRead = {lowFreqSourceSelect_q, multEnable_q, 1'b0,
                           tuningField_q};
  wire [7:0] controlRead = {idleOnSleep_q, internalFreqSelect_q, srcFlags.primaryReady,
                            srcFlags.internalStable, clockSourceSelect_q};
  wire [7:0] readByte = selTuning ? tuningRead : selControl ? controlRead : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setupPhase) begin
      prdata <= {24'h00_0000, readByte};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  mult_gate_a: assert property (
      multActive |-> multAvail && freqAllowsMult && multEnable_q)
    else $error("multiplier active outside its allowed setting");

  mult_forced_a: assert property (!multAvail |=> !multEnable_q)
    else $error("multiplier enable not held low when unavailable");

  scs_refuse_a: assert property (
      wrControl && scsRefused |=> $stable(clockSourceSelect_q))
    else $error("secondary select taken without timer oscillator");

  select_taken_a: assert property (
      wrControl && !scsRefused |=> clockSourceSelect_q == $past(scsWrite))
    else $error("clock select write not taken");

  freq_write_a: assert property (
      wrControl |=> internalFreqSelect_q == $past(pwdata[6:4]))
    else $error("frequency select not updated at once");

  direct_fast_a: assert property (
      internalFreqSelect_q == csoc_pkg::FREQ_8M |-> internalTick == fastTick)
    else $error("top setting not driven straight from the fast oscillator");

  low_source_a: assert property (
      lowSelected && !lowFreqSourceSelect_q |-> internalTick == slowTick && !fastOscEnable)
    else $error("low frequency setting not taken from the slow oscillator");

  fast_enable_a: assert property (!lowSelected |-> fastOscEnable)
    else $error("fast oscillator off while a postscaler setting is selected");

  switch_pause_a: assert property (swState_q == SW_RUN && reqSrc != activeSrc_q
      |=> !deviceClkEn [*3])
    else $error("device clock ran during source switch");

  switch_done_a: assert property (
      swState_q == SW_WAIT_NEW && newTick && swCount_q == csoc_pkg::NEW_SRC_CYCLES - 3'h1
      |=> activeSrc_q == $past(targetSrc_q) && !switchBusy)
    else $error("switch did not complete onto the requested source");

  flags_onehot_a: assert property ($onehot0(srcFlags))
    else $error("more than one source flag set");

  primary_flag_a: assert property (
      srcFlags.primaryReady |-> activeSrc_q == csoc_pkg::SRC_PRIMARY && startupDone)
    else $error("primary ready flag without primary clocking");

  sleep_mode_a: assert property (sleepExec |=> idleEnter == $past(idleOnSleep_q)
      && sleepEnter == !$past(idleOnSleep_q))
    else $error("wrong low power mode entered");

  tune_read_a: assert property (psel && penable && !pwrite && selTuning
      |-> prdata[5] == 1'b0 && (prdata[6] == 1'b0 || multAvail))
    else $error("tuning readback shows reserved or forced bit set");

  trim_write_a: assert property (
      wrTuning |=> fastOscTrim == $signed($past(pwdata[4:0])))
    else $error("trim output not following tuning write");

  int_stable_a: assert property (srcFlags.internalStable
      |-> activeSrc_q == csoc_pkg::SRC_INTERNAL && fastStable)
    else $error("internal stable flag without internal clocking");

endmodule

// ==== testbench/csoc_ctrl_test.sv ====
// self-checking bench for the clock source and oscillator control block
module csoc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [7:0] TUN = csoc_pkg::ADDR_OSC_TUNING;
  localparam logic [7:0] CTL = csoc_pkg::ADDR_OSC_CONTROL;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, deviceClkEn, switchBusy, multActive, fastOscEnable;
  logic slowOscEnable, watchdogClkEn, idleEnter, sleepEnter;
  logic [3:0] primaryOscConfig = 4'h9;
  logic secondaryOscEnable = 1'b0;
  logic sleepExec = 1'b0;
  logic startupPin = 1'b0;
  logic stablePin = 1'b0;
  logic [7:0] cyc = 8'h00;
  csoc_pkg::csoc_osc_s oscPins;
  csoc_pkg::csoc_src_e activeSource;
  logic signed [4:0] fastOscTrim;
  csoc_pkg::csoc_flags_s srcFlags;
  int errTotal = 0;
  int nChecks = 0;
  logic [32:0] expQ[$];
  logic [31:0] mskQ[$];
  string nameQ[$];

  always #25 clk_sys = ~clk_sys;

  // free-running oscillators: fast 4, primary 8, secondary 16, slow 32 cycles a period
  always @(posedge clk_sys) cyc <= cyc + 8'h01;
  assign oscPins = '{primaryTick: cyc[2], secondaryTick: cyc[3], fastTick: cyc[1],
                     slowTick: cyc[4], startupExpired: startupPin, fastStable: stablePin};

  csoc_ctrl i_csoc_ctrl (
    .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primaryOscConfig(primaryOscConfig), .secondaryOscEnable(secondaryOscEnable),
    .sleepExec(sleepExec), .oscPins(oscPins), .deviceClkEn(deviceClkEn),
    .activeSource(activeSource), .switchBusy(switchBusy), .multActive(multActive),
    .fastOscEnable(fastOscEnable), .slowOscEnable(slowOscEnable),
    .watchdogClkEn(watchdogClkEn), .fastOscTrim(fastOscTrim), .srcFlags(srcFlags),
    .idleEnter(idleEnter), .sleepEnter(sleepEnter)
  );

  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errTotal == 0 && nChecks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp_port(input string nm, input logic [7:0] e, input logic [7:0] g);
    nChecks++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_read(input string nm, input logic [32:0] e, input logic [32:0] g);
    nChecks++;
    if (g !== e) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // the oldest noted read is settled at the edge that completes the access
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      if (expQ.size() == 0) begin
        errTotal++;
        $display("MISMATCH unexpectedRead expected none seen %h", prdata);
      end else
        cmp_read(nameQ.pop_front(), expQ.pop_front(), {pslverr, prdata & mskQ.pop_front()});
    end
  end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  // a stuck access is ended by the watchdog alone, never by the driver
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0,
                    input logic [7:0] m = 8'hFF);
    expQ.push_back({err, 24'h000000, e & m});
    mskQ.push_back({24'hFFFFFF, m});
    nameQ.push_back($sformatf("read%h", a));
    apb(1'b0, a, 32'h00000000);
  endtask

  task automatic count_ticks(output int nClk, output int nWd);
    nClk = 0;
    nWd = 0;
    repeat (8) @(posedge clk_sys);
    repeat (64) begin
      @(posedge clk_sys);
      if (deviceClkEn === 1'b1) nClk++;
      if (watchdogClkEn === 1'b1) nWd++;
    end
  endtask

  // pause length is bounded by old and new periods plus synchroniser latency
  task automatic switch_to(input logic [7:0] ctl, input int lo, input int hi,
                           input csoc_pkg::csoc_src_e src);
    int n, b, bad;
    n = 0;
    b = 0;
    bad = 0;
    wr(CTL, ctl);
    while (switchBusy !== 1'b1 && n < 6) begin
      @(posedge clk_sys);
      n++;
    end
    while (switchBusy === 1'b1 && b < 200) begin
      @(posedge clk_sys);
      b++;
      if (deviceClkEn === 1'b1) bad++;
    end
    #1;
    cmp_port("pauseInRange", 8'h01, {7'h00, (b >= lo && b <= hi)});
    cmp_port("clkInPause", 8'h00, 8'(bad));
    cmp_port("activeSource", {6'h00, src}, {6'h00, activeSource});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    int nClk, nWd;
    logic [7:0] tv[7];
    void'($urandom(54));
    tv = '{8'h00, 8'h0F, 8'h10, 8'h1F, 8'h00, 8'h00, 8'h00};
    for (int i = 4; i < 7; i++) tv[i] = 8'($urandom_range(31, 0));
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(TUN, 8'h00);
    rd(CTL, 8'h40);
    #1;
    cmp_port("activeSource", 8'h00, {6'h00, activeSource});
    cmp_port("stableFlag", 8'h00, {7'h00, srcFlags.internalStable});
    startupPin <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(CTL, 8'h48);
    wr(CTL, 8'h44);
    rd(CTL, 8'h48);
    wr(TUN, 8'h7F);
    rd(TUN, 8'h5F);
    for (int f = 0; f < 8; f++) begin
      wr(CTL, 8'(f << 4));
      #1;
      cmp_port("multActive", {7'h00, f >= 6}, {7'h00, multActive});
    end
    primaryOscConfig <= 4'h8;
    @(posedge clk_sys);
    #1;
    cmp_port("multActive", 8'h01, {7'h00, multActive});
    wr(TUN, 8'h1F);
    #1;
    cmp_port("multActive", 8'h00, {7'h00, multActive});
    wr(TUN, 8'h40);
    primaryOscConfig <= 4'h6;
    @(posedge clk_sys);
    #1;
    cmp_port("multActive", 8'h00, {7'h00, multActive});
    rd(TUN, 8'h00);
    wr(TUN, 8'h40);
    rd(TUN, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(TUN, tv[i]);
      rd(TUN, tv[i]);
      #1;
      cmp_port("trim", tv[i], {3'b000, fastOscTrim});
    end
    rd(8'h08, 8'h00, 1'b1);
    wr(8'h0C, 8'hFF);
    rd(TUN, tv[6]);
    count_ticks(nClk, nWd);
    cmp_port("primaryClocks", 8'h08, 8'(nClk));
    cmp_port("watchdogTicks", 8'h02, 8'(nWd));
    wr(CTL, 8'h71);
    rd(CTL, 8'h78);
    stablePin <= 1'b1;
    switch_to(8'h72, 14, 44, csoc_pkg::SRC_INTERNAL);
    cmp_port("stableFlag", 8'h01, {7'h00, srcFlags.internalStable});
    cmp_port("oneFlag", 8'h01, {7'h00, $onehot0(srcFlags)});
    for (int f = 7; f >= 3; f--) begin
      wr(CTL, 8'(f << 4) | 8'h02);
      count_ticks(nClk, nWd);
      cmp_port("internalClocks", 8'h10 >> (7 - f), 8'(nClk));
    end
    wr(CTL, 8'h02);
    #1;
    cmp_port("fastEnable", 8'h00, {7'h00, fastOscEnable});
    count_ticks(nClk, nWd);
    cmp_port("slowClocks", 8'h02, 8'(nClk));
    wr(TUN, 8'h80);
    #1;
    cmp_port("fastEnable", 8'h01, {7'h00, fastOscEnable});
    count_ticks(nClk, nWd);
    cmp_port("watchdogTicks", 8'h02, 8'(nWd));
    cmp_port("slowEnable", 8'h01, {7'h00, slowOscEnable});
    wr(CTL, 8'h72);
    secondaryOscEnable <= 1'b1;
    switch_to(8'h71, 44, 84, csoc_pkg::SRC_SECONDARY);
    cmp_port("secFlag", 8'h01, {7'h00, srcFlags.secondaryRunning});
    cmp_port("oneFlag", 8'h01, {7'h00, $onehot0(srcFlags)});
    count_ticks(nClk, nWd);
    cmp_port("secondaryClocks", 8'h04, 8'(nClk));
    for (int k = 0; k < 2; k++) begin
      wr(CTL, k == 0 ? 8'hF1 : 8'h71);
      sleepExec <= 1'b1;
      @(posedge clk_sys);
      sleepExec <= 1'b0;
      #1;
      cmp_port("idleEnter", {7'h00, k == 0}, {7'h00, idleEnter});
      cmp_port("sleepEnter", {7'h00, k == 1}, {7'h00, sleepEnter});
    end
    arst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    cmp_port("activeSource", 8'h00, {6'h00, activeSource});
    rd(CTL, 8'h40, 1'b0, 8'hF7);
    rd(TUN, 8'h00);
    conclude();
  end

  // the scenarios need about a thousand cycles; this margin only catches hangs
  initial begin
    repeat (20000) @(posedge clk_sys);
    errTotal++;
    conclude();
  end
endmodule
